// *** src/pgm_regs.sv ***
`timescale 1ns/100ps
// How it works
// - gating bit 0 blocks low address byte
// - extended mode address from port F, bus
// - bits 4..2 block control inputs 2..0
// - bit 5 blocks address latch strobe
// - bit 6 blocks high byte write strobe
// - reset loads map bits 1-4, clears 0,7
// - map bits 0-4 act only in extended mode
// - map bits 0-2 allow fetch strobe access
// - map bits 3-4 allow read strobe access
// - map bit 7 enables port F peripheral
// - info0 low nibble: primary flash size
// - info0 high nibble: SRAM size
// - info1 low nibble: secondary size
// - info1 bits 5:4: secondary memory type
// - sector selects come from decode array
module pgm_regs #(
	parameter logic [3:0] PRI_SIZE  = pgm_pkg::PRI_4MBIT,
	parameter logic [3:0] SRAM_SIZE = pgm_pkg::SRAM_64K,
	parameter logic [3:0] SEC_SIZE  = pgm_pkg::SEC_256K,
	parameter logic [1:0] SEC_TYPE  = pgm_pkg::SEC_FLASH,
	parameter logic [7:0] MAP_CFG   = pgm_pkg::MAP_CFG_MASK
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [1:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// bus configuration
	input  wire logic        extended_bus_mode,
	// raw bus inputs
	input  wire logic [7:0]  addr_low,
	input  wire logic [3:0]  port_f_low_pins,
	input  wire logic [3:0]  muxed_bus_upper_pins,
	input  wire logic [2:0]  control_in,
	input  wire logic        ale_in,
	input  wire logic        high_byte_write_strobe,
	input  wire logic        program_fetch_strobe,
	input  wire logic        read_strobe,
	// decode array terms
	input  wire logic [7:0]  pri_term,
	input  wire logic [3:0]  sec_term,
	input  wire logic        sram_term,
	// array inputs after gating
	output logic      [7:0]  array_addr,
	output logic      [2:0]  array_ctl,
	output logic             array_ale,
	output logic             array_wrh,
	// access permissions
	output logic             sram_fetch_ok,
	output logic             sec_fetch_ok,
	output logic             pri_fetch_ok,
	output logic             sec_read_ok,
	output logic             pri_read_ok,
	output logic             port_f_periph,
	// memory selects
	output logic      [7:0]  primary_sector_selects,
	output logic      [3:0]  secondary_sector_selects,
	output logic             sram_select
);
	logic [7:0] gating;
	logic [7:0] memory_space_map;
	logic [7:0] next_gating;
	logic [7:0] next_memory_space_map;
	logic [7:0] next_rdata;
	logic [7:0] addr_src;
	logic       sram_fetch_allow;
	logic       primary_fetch_allow;
	logic       primary_read_allow;
	logic       next_sf;
	logic       next_bf;
	logic       next_pf;
	logic       next_br;
	logic       next_pr;
	logic       next_per;

	// read-back value of a register index
	function automatic logic [7:0] rd_mux(input logic [1:0] a,
			input logic [7:0] g, input logic [7:0] m);
		case (a)
			pgm_pkg::REG_GATING: rd_mux = g & pgm_pkg::GATING_MASK;
			pgm_pkg::REG_MAP:    rd_mux = m & pgm_pkg::MAP_MASK;
			pgm_pkg::REG_INFO0:  rd_mux = {SRAM_SIZE, PRI_SIZE};
			pgm_pkg::REG_INFO1:  rd_mux = {2'h0, SEC_TYPE, SEC_SIZE};
			default:             rd_mux = 8'h00;
		endcase
	endfunction

	// register writes; unused bits are never stored
	always_comb begin
		next_gating = gating;
		next_memory_space_map = memory_space_map;
		next_rdata  = 8'h00;
		if (reg_wr && reg_addr == pgm_pkg::REG_GATING)
			next_gating = reg_wdata & pgm_pkg::GATING_MASK;
		if (reg_wr && reg_addr == pgm_pkg::REG_MAP)
			next_memory_space_map = reg_wdata & pgm_pkg::MAP_MASK;
		if (reg_rd)
			next_rdata = rd_mux(reg_addr, gating, memory_space_map);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gating    <= pgm_pkg::GATING_RESET;
			memory_space_map <= MAP_CFG & pgm_pkg::MAP_CFG_MASK;
			reg_rdata <= 8'h00;
		end else begin
			gating    <= next_gating;
			memory_space_map <= next_memory_space_map;
			reg_rdata <= next_rdata;
		end
	end

	// extended mode splits the low address over two pin groups
	always_comb begin
		if (extended_bus_mode)
			addr_src = {muxed_bus_upper_pins, port_f_low_pins};
		else
			addr_src = addr_low;
	end

	// map bits only restrict access in extended mode; else all pass
	assign sram_fetch_allow    = memory_space_map[pgm_pkg::MP_SRAM_FETCH];
	assign primary_fetch_allow = memory_space_map[pgm_pkg::MP_PRI_FETCH];
	assign primary_read_allow  = memory_space_map[pgm_pkg::MP_PRI_READ];
	always_comb begin
		next_sf  = program_fetch_strobe
			& (~extended_bus_mode | sram_fetch_allow);
		next_bf  = program_fetch_strobe
			& (~extended_bus_mode
			| memory_space_map[pgm_pkg::MP_SEC_FETCH]);
		next_pf  = program_fetch_strobe
			& (~extended_bus_mode | primary_fetch_allow);
		next_br  = read_strobe
			& (~extended_bus_mode
			| memory_space_map[pgm_pkg::MP_SEC_READ]);
		next_pr  = read_strobe
			& (~extended_bus_mode | primary_read_allow);
		next_per = memory_space_map[pgm_pkg::MP_PERIPH];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sram_fetch_ok <= 1'b0;
			sec_fetch_ok  <= 1'b0;
			pri_fetch_ok  <= 1'b0;
			sec_read_ok   <= 1'b0;
			pri_read_ok   <= 1'b0;
			port_f_periph <= 1'b0;
		end else begin
			sram_fetch_ok <= next_sf;
			sec_fetch_ok  <= next_bf;
			pri_fetch_ok  <= next_pf;
			sec_read_ok   <= next_br;
			pri_read_ok   <= next_pr;
			port_f_periph <= next_per;
		end
	end

	// gating of array inputs
	pgm_gate pgm_gate_inst (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.addr_in  (addr_src),
		.ctl_in   (control_in),
		.ale_in   (ale_in),
		.wrh_in   (high_byte_write_strobe),
		.gating   (gating),
		.addr_out (array_addr),
		.ctl_out  (array_ctl),
		.ale_out  (array_ale),
		.wrh_out  (array_wrh)
	);

	// memory selects
	pgm_sel pgm_sel_inst (
		.clk                      (clk),
		.sys_rst                  (sys_rst),
		.pri_term                 (pri_term),
		.sec_term                 (sec_term),
		.sram_term                (sram_term),
		.primary_sector_selects   (primary_sector_selects),
		.secondary_sector_selects (secondary_sector_selects),
		.sram_select              (sram_select)
	);

	// checks on the gated array inputs; each lags its source by one edge

	addr_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(gating[pgm_pkg::GT_ADDR]) |-> array_addr == 8'h00)
		else $error("blocked address reached array");

	addr_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(gating[pgm_pkg::GT_ADDR]) |-> array_addr == $past(addr_src))
		else $error("address not passed");

	// the pin groups are checked, not the internal mux, so a swap shows
	ext_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode) && !$past(gating[pgm_pkg::GT_ADDR])
		|-> array_addr == {$past(muxed_bus_upper_pins),
		$past(port_f_low_pins)})
		else $error("extended address wrong");

	low_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(extended_bus_mode) && !$past(gating[pgm_pkg::GT_ADDR])
		|-> array_addr == $past(addr_low))
		else $error("low address wrong");

	ctl_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(gating[pgm_pkg::GT_CTL2]) |-> !array_ctl[2])
		else $error("control 2 not blocked");

	ctl0_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(gating[pgm_pkg::GT_CTL0]) |-> !array_ctl[0])
		else $error("control 0 not blocked");

	ctl1_block_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(gating[pgm_pkg::GT_CTL1]) |-> !array_ctl[1])
		else $error("control 1 not blocked");

	ctl_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		array_ctl == ($past(control_in)
		& ~$past(gating[pgm_pkg::GT_CTL2:pgm_pkg::GT_CTL0])))
		else $error("control gating wrong");

	ale_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		array_ale == ($past(ale_in) & !$past(gating[pgm_pkg::GT_ALE])))
		else $error("latch strobe gating wrong");

	wrh_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(gating[pgm_pkg::GT_WRH]) |-> !array_wrh)
		else $error("high write strobe not blocked");

	wrh_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(gating[pgm_pkg::GT_WRH])
		|-> array_wrh == $past(high_byte_write_strobe))
		else $error("high write strobe not passed");

	// reset values, looked at on the first edge after release only

	map_reset_a: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst |-> memory_space_map[0] == 1'b0
		&& memory_space_map[7] == 1'b0)
		else $error("map reset wrong");

	map_cfg_a: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst
		|-> memory_space_map == (MAP_CFG & pgm_pkg::MAP_CFG_MASK))
		else $error("map build value not loaded");

	gating_reset_a: assert property (@(posedge clk)
		$past(sys_rst) && !sys_rst
		|-> gating == pgm_pkg::GATING_RESET)
		else $error("gating reset wrong");

	// register writes land one edge after the strobe

	gating_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_wr) && $past(reg_addr) == pgm_pkg::REG_GATING
		|-> gating == ($past(reg_wdata) & pgm_pkg::GATING_MASK))
		else $error("gating write lost");

	map_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_wr) && $past(reg_addr) == pgm_pkg::REG_MAP
		|-> memory_space_map == ($past(reg_wdata) & pgm_pkg::MAP_MASK))
		else $error("map write lost");

	unused_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
		(gating & ~pgm_pkg::GATING_MASK) == 8'h00
		&& (memory_space_map & ~pgm_pkg::MAP_MASK) == 8'h00)
		else $error("unused register bit stored");

	// access permits in extended mode

	fetch_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode)
		&& !$past(memory_space_map[pgm_pkg::MP_PRI_FETCH])
		|-> !pri_fetch_ok)
		else $error("fetch not denied");

	sram_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode)
		&& !$past(memory_space_map[pgm_pkg::MP_SRAM_FETCH])
		|-> !sram_fetch_ok)
		else $error("sram fetch not denied");

	sec_fetch_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode)
		&& !$past(memory_space_map[pgm_pkg::MP_SEC_FETCH])
		|-> !sec_fetch_ok)
		else $error("secondary fetch not denied");

	sec_read_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode)
		&& !$past(memory_space_map[pgm_pkg::MP_SEC_READ])
		|-> !sec_read_ok)
		else $error("secondary read not denied");

	pri_read_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(extended_bus_mode)
		&& !$past(memory_space_map[pgm_pkg::MP_PRI_READ])
		|-> !pri_read_ok)
		else $error("primary read not denied");

	// outside extended mode the strobes pass whatever the map says

	read_free_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(extended_bus_mode) |-> sec_read_ok == $past(read_strobe))
		else $error("read restricted outside extended mode");

	fetch_free_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(extended_bus_mode)
		|-> pri_fetch_ok == $past(program_fetch_strobe))
		else $error("fetch restricted outside extended mode");

	periph_map_a: assert property (@(posedge clk) disable iff (sys_rst)
		port_f_periph == $past(memory_space_map[pgm_pkg::MP_PERIPH]))
		else $error("peripheral mode wrong");

	// read port: data only in the cycle after the strobe

	info_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_rd) && $past(reg_addr) == pgm_pkg::REG_INFO1
		|-> reg_rdata[7:6] == 2'h0)
		else $error("unused id bits not zero");

	info0_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_rd) && $past(reg_addr) == pgm_pkg::REG_INFO0
		|-> reg_rdata == {SRAM_SIZE, PRI_SIZE})
		else $error("size info 0 wrong");

	info1_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		$past(reg_rd) && $past(reg_addr) == pgm_pkg::REG_INFO1
		|-> reg_rdata[5:0] == {SEC_TYPE, SEC_SIZE})
		else $error("size info 1 wrong");

	rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	// selects are plain registered copies of the decode terms

	sel_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		primary_sector_selects == $past(pri_term)
		&& secondary_sector_selects == $past(sec_term)
		&& sram_select == $past(sram_term))
		else $error("memory selects wrong");
endmodule

// *** src/pgm_pkg.sv ***
package pgm_pkg;
	// register indices on the plain port
	localparam logic [1:0] REG_GATING = 2'h0;
	localparam logic [1:0] REG_MAP    = 2'h1;
	localparam logic [1:0] REG_INFO0  = 2'h2;
	localparam logic [1:0] REG_INFO1  = 2'h3;
	localparam int ADDR_W = 2;
	// gating register fields
	localparam int GT_ADDR = 0;
	localparam int GT_CTL0 = 2;
	localparam int GT_CTL1 = 3;
	localparam int GT_CTL2 = 4;
	localparam int GT_ALE  = 5;
	localparam int GT_WRH  = 6;
	localparam logic [7:0] GATING_MASK  = 8'h7d;
	localparam logic [7:0] GATING_RESET = 8'h00;
	// map register fields
	localparam int MP_SRAM_FETCH = 0;
	localparam int MP_SEC_FETCH  = 1;
	localparam int MP_PRI_FETCH  = 2;
	localparam int MP_SEC_READ   = 3;
	localparam int MP_PRI_READ   = 4;
	localparam int MP_PERIPH     = 7;
	localparam logic [7:0] MAP_MASK     = 8'h9f;
	localparam logic [7:0] MAP_CFG_MASK = 8'h1e;
	// identification codes
	localparam logic [3:0] PRI_4MBIT  = 4'h4;
	localparam logic [3:0] PRI_8MBIT  = 4'h5;
	localparam logic [3:0] SRAM_NONE  = 4'h0;
	localparam logic [3:0] SRAM_16K   = 4'h1;
	localparam logic [3:0] SRAM_64K   = 4'h3;
	localparam logic [3:0] SEC_NONE   = 4'h0;
	localparam logic [3:0] SEC_256K   = 4'h2;
	localparam logic [1:0] SEC_FLASH  = 2'h0;
	localparam logic [1:0] SEC_EEPROM = 2'h1;
	// memory organisation
	localparam int PRI_SECTORS = 8;
	localparam int SEC_SECTORS = 4;
	localparam int PRI_SECT_KB = 64;
	localparam int SEC_SECT_KB = 8;
	localparam int SRAM_KB     = 16;
endpackage

// *** src/pgm_gate.sv ***
`timescale 1ns/100ps
module pgm_gate (
	// clock
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// raw inputs and gating bits
	input  wire logic [7:0] addr_in,
	input  wire logic [2:0] ctl_in,
	input  wire logic       ale_in,
	input  wire logic       wrh_in,
	input  wire logic [7:0] gating,
	// array side
	output logic      [7:0] addr_out,
	output logic      [2:0] ctl_out,
	output logic            ale_out,
	output logic            wrh_out
);
	logic [7:0] next_addr;
	logic [2:0] next_ctl;
	logic       next_ale;
	logic       next_wrh;

	// a blocked input holds low so the array sees no toggling
	always_comb begin
		next_addr = gating[pgm_pkg::GT_ADDR] ? 8'h00 : addr_in;
		next_ctl[0] = ctl_in[0] & ~gating[pgm_pkg::GT_CTL0];
		next_ctl[1] = ctl_in[1] & ~gating[pgm_pkg::GT_CTL1];
		next_ctl[2] = ctl_in[2] & ~gating[pgm_pkg::GT_CTL2];
		next_ale = ale_in & ~gating[pgm_pkg::GT_ALE];
		next_wrh = wrh_in & ~gating[pgm_pkg::GT_WRH];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_out <= 8'h00;
			ctl_out  <= 3'h0;
			ale_out  <= 1'b0;
			wrh_out  <= 1'b0;
		end else begin
			addr_out <= next_addr;
			ctl_out  <= next_ctl;
			ale_out  <= next_ale;
			wrh_out  <= next_wrh;
		end
	end
endmodule

// *** src/pgm_sel.sv ***
`timescale 1ns/100ps
module pgm_sel (
	// clock
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// select terms from the decode logic array
	input  wire logic [7:0] pri_term,
	input  wire logic [3:0] sec_term,
	input  wire logic       sram_term,
	// registered selects
	output logic      [7:0] primary_sector_selects,
	output logic      [3:0] secondary_sector_selects,
	output logic            sram_select
);
	logic [7:0] next_pri;
	logic [3:0] next_sec;
	logic       next_sram;

	// one select per sector, passed straight from the array
	always_comb begin
		next_pri  = pri_term;
		next_sec  = sec_term;
		next_sram = sram_term;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			primary_sector_selects   <= 8'h00;
			secondary_sector_selects <= 4'h0;
			sram_select              <= 1'b0;
		end else begin
			primary_sector_selects   <= next_pri;
			secondary_sector_selects <= next_sec;
			sram_select              <= next_sram;
		end
	end
endmodule

// *** testbench/pgm_host.sv ***
`timescale 1ns/100ps
module pgm_host (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [1:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	// bus idle at time zero
	initial begin
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// unused bits go out as zero unless raw asks for a refusal test
	task automatic wr(input logic [1:0] a, input logic [7:0] d, input bit raw);
		logic [7:0] used;
		used = (a == pgm_pkg::REG_GATING) ? pgm_pkg::GATING_MASK
			: pgm_pkg::MAP_MASK;
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= raw ? d : (d & used);
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // released data must not look stale
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// *** testbench/test_pld_gating_and_memory_map_regs.sv ***
`timescale 1ns/100ps
module test_pld_gating_and_memory_map_regs;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [1:0] ra;
	logic [7:0] wd, rdat, al = 8'h00, pt = 8'h00, a_addr, p_sel;
	logic       wr, rd, ext = 1'b0, ale = 1'b0, wrh = 1'b0, st = 1'b0;
	logic       fe = 1'b0, rs = 1'b0, a_ale, a_wrh, s_sel;
	logic [3:0] pf = 4'h0, mx = 4'h0, sct = 4'h0, c_sel;
	logic [2:0] ctl = 3'h0, a_ctl;
	logic       sf, bf, pfo, br, pr, per;
	logic [7:0] d;
	int         fails = 0;
	int         checks = 0;
	logic [7:0] gl[7] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
	logic [7:0] ml[8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80,
		8'h9f};

	pgm_host pgm_host_inst (.clk(clk), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));

	pgm_regs #(.PRI_SIZE(pgm_pkg::PRI_8MBIT), .SRAM_SIZE(pgm_pkg::SRAM_16K),
		.SEC_SIZE(pgm_pkg::SEC_256K), .SEC_TYPE(pgm_pkg::SEC_EEPROM),
		.MAP_CFG(8'hff)) pgm_regs_inst (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdat), .extended_bus_mode(ext), .addr_low(al),
		.port_f_low_pins(pf), .muxed_bus_upper_pins(mx), .control_in(ctl),
		.ale_in(ale), .high_byte_write_strobe(wrh),
		.program_fetch_strobe(fe), .read_strobe(rs), .pri_term(pt),
		.sec_term(sct), .sram_term(st), .array_addr(a_addr),
		.array_ctl(a_ctl), .array_ale(a_ale), .array_wrh(a_wrh),
		.sram_fetch_ok(sf), .sec_fetch_ok(bf), .pri_fetch_ok(pfo),
		.sec_read_ok(br), .pri_read_ok(pr), .port_f_periph(per),
		.primary_sector_selects(p_sel), .secondary_sector_selects(c_sel),
		.sram_select(s_sel));

	// clock of 8 ns
	always #4 clk = ~clk;

	task automatic check(input string n, input logic [7:0] e,
			input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic conclude;
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one edge to sample inputs, then look at settled outputs
	task automatic settle;
		@(posedge clk);
		#1;
	endtask

	task automatic reset_values;
		pgm_host_inst.rd(pgm_pkg::REG_MAP, d);
		check("map reset", 8'h1e, d);
		pgm_host_inst.rd(pgm_pkg::REG_GATING, d);
		check("gating reset", 8'h00, d);
		pgm_host_inst.wr(pgm_pkg::REG_INFO0, 8'hff, 1);
		pgm_host_inst.rd(pgm_pkg::REG_INFO0, d);
		check("info0", 8'h15, d);
		pgm_host_inst.rd(pgm_pkg::REG_INFO1, d);
		check("info1", 8'h12, d);
	endtask

	// every gating bit alone, all gated inputs held high
	task automatic gating_bits;
		@(posedge clk);
		{al, ctl, ale, wrh} <= '1;
		foreach (gl[i]) begin
			pgm_host_inst.wr(pgm_pkg::REG_GATING, gl[i], 0);
			settle();
			check("array addr", gl[i][0] ? 8'h00 : 8'hff, a_addr);
			check("array ctl", {5'h0, ~gl[i][4:2]}, {5'h0, a_ctl});
			check("array ale", {7'h0, ~gl[i][5]}, {7'h0, a_ale});
			check("array wrh", {7'h0, ~gl[i][6]}, {7'h0, a_wrh});
		end
		pgm_host_inst.wr(pgm_pkg::REG_GATING, 8'hff, 1);
		pgm_host_inst.rd(pgm_pkg::REG_GATING, d);
		check("gating unused", 8'h7d, d);
	endtask

	// address source moves with the bus mode; gating still blocks
	task automatic ext_address;
		pgm_host_inst.wr(pgm_pkg::REG_GATING, 8'h00, 0);
		@(posedge clk);
		{ext, al, pf, mx} <= {1'b1, 8'h3c, 4'h5, 4'ha};
		settle();
		check("ext addr", 8'ha5, a_addr);
		pgm_host_inst.wr(pgm_pkg::REG_GATING, 8'h01, 0);
		settle();
		check("ext blocked", 8'h00, a_addr);
		pgm_host_inst.wr(pgm_pkg::REG_GATING, 8'h00, 0);
		ext <= 1'b0;
		settle();
		check("low addr", 8'h3c, a_addr);
	endtask

	// permits in both modes, strobes asserted, then fetch dropped
	task automatic map_bits;
		logic [4:0] pm;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			{ext, fe, rs} <= {m[0], 2'b11};
			foreach (ml[i]) begin
				pgm_host_inst.wr(pgm_pkg::REG_MAP, ml[i], 0);
				settle();
				pm = m[0] ? ml[i][4:0] : 5'h1f;
				check("permits", {3'h0, pm}, {3'h0, pr, br, pfo, bf, sf});
				check("periph", {7'h0, ml[i][7]}, {7'h0, per});
			end
		end
		fe <= 1'b0;
		settle();
		check("no fetch", 8'h18, {3'h0, pr, br, pfo, bf, sf});
		pgm_host_inst.wr(pgm_pkg::REG_MAP, 8'hff, 1);
		pgm_host_inst.rd(pgm_pkg::REG_MAP, d);
		check("map unused", 8'h9f, d);
	endtask

	// selects follow the decode terms one cycle later
	task automatic selects;
		@(posedge clk);
		{pt, sct, st} <= {8'ha5, 4'h5, 1'b1};
		settle();
		check("pri sel", 8'ha5, p_sel);
		check("sec sel", 8'h05, {4'h0, c_sel});
		{pt, sct, st} <= {8'h5a, 4'ha, 1'b0};
		settle();
		check("pri sel", 8'h5a, p_sel);
		check("sec sram sel", 8'h0a, {3'h0, s_sel, c_sel});
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		reset_values();
		gating_bits();
		ext_address();
		map_bits();
		selects();
		conclude();
	end
endmodule
